// *** hw/fsl_host.sv ***
// Host controller issuing pin-mode and block-lock command sequences
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module fsl_host #(
  parameter int ADDR_W     = 24,
  parameter int STROBE     = fsl_pkg::STROBE_CYC,
  parameter int POLL_LIMIT = 65535
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [3:0]        sw_addr,
  input  wire logic [31:0]       sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  output logic [31:0]            sw_rdata,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [15:0]            flash_dq_out,
  output logic                   flash_dq_oe_n,
  input  wire logic [15:0]       flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic                   reset_pin,
  input  wire logic              status_output_pin
);
  typedef enum {S_IDLE, S_CHK_CMD, S_CHK_RD, S_WR1, S_WR2, S_POLL, S_QCMD,
                S_QRD, S_DONE} fsl_state_t;

  fsl_state_t          state, next_state;
  logic [ADDR_W-1:0]   tgt, next_tgt;
  logic [7:0]          cfg, next_cfg;
  logic [2:0]          op, next_op;
  logic [7:0]          dstat, next_dstat;
  logic                busy, next_busy;
  logic                locked, next_locked;
  logic                refused, next_refused;
  logic                timeout, next_timeout;
  logic [1:0]          pin_mode, next_pin_mode;
  logic [15:0]         cnt, next_cnt;
  logic [15:0]         polls, next_polls;
  logic [31:0]         next_rdata;
  fsl_pkg::fsl_cycle_t cyc, next_cyc;
  logic                rd_en, next_rd_en;
  logic [7:0]          pulse_count;

  fsl_pulse_catch #(.MIN_LOW(fsl_pkg::PULSE_MIN_CYC)) u_catch (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .pin_low    (!status_output_pin),
    .pulse_count(pulse_count)
  );

  // Second cycle command word for a pin-config or lock operation
  function automatic logic [15:0] confirm_code(input logic [2:0] o,
                                               input logic [7:0] c);
    case (o)
      fsl_pkg::OP_PIN_CFG:  confirm_code = {8'h00, c};
      fsl_pkg::OP_LOCK_SET: confirm_code = fsl_pkg::CMD_LOCK_SET;
      default:              confirm_code = fsl_pkg::CMD_LOCK_CLEAR;
    endcase
  endfunction

  function automatic logic [15:0] first_code(input logic [2:0] o);
    case (o)
      fsl_pkg::OP_PIN_CFG:    first_code = fsl_pkg::CMD_PIN_CFG_SETUP;
      fsl_pkg::OP_CLR_STATUS: first_code = fsl_pkg::CMD_CLEAR_STATUS;
      default:                first_code = fsl_pkg::CMD_LOCK_SETUP;
    endcase
  endfunction

  always_comb begin
    next_state    = state;
    next_tgt      = tgt;
    next_cfg      = cfg;
    next_op       = op;
    next_dstat    = dstat;
    next_busy     = busy;
    next_locked   = locked;
    next_refused  = refused;
    next_timeout  = timeout;
    next_pin_mode = pin_mode;
    next_cnt      = cnt;
    next_polls    = polls;
    next_cyc      = cyc;
    next_rd_en    = 1'b0;
    next_rdata    = 32'h0000_0000;
    if (sw_rd) begin
      case (sw_addr)
        fsl_pkg::REG_ADDR:   next_rdata = 32'(tgt);
        fsl_pkg::REG_CFG:    next_rdata = {24'h000000, cfg};
        fsl_pkg::REG_STATUS: next_rdata = {pulse_count, 18'h00000, pin_mode,
                                           timeout, refused, locked, busy};
        fsl_pkg::REG_RESULT: next_rdata = {24'h000000, dstat};
        default:             next_rdata = 32'h0000_0000;
      endcase
    end
    if (sw_wr && !busy) begin
      case (sw_addr)
        fsl_pkg::REG_ADDR: next_tgt = sw_wdata[ADDR_W-1:0];
        fsl_pkg::REG_CFG:  next_cfg = sw_wdata[7:0];
        fsl_pkg::REG_CTRL: begin
          next_op      = sw_wdata[2:0];
          next_busy    = 1'b1;
          next_refused = 1'b0;
          next_timeout = 1'b0;
          next_state   = (sw_wdata[2:0] == fsl_pkg::OP_LOCK_QUERY) ? S_QCMD
                       : (sw_wdata[2:0] == fsl_pkg::OP_CLR_STATUS) ? S_WR2
                       : S_CHK_CMD;
        end
        default: ;
      endcase
    end
    // Each flash access: phases 0 to STROBE-1 assert, phase STROBE releases
    case (state)
      S_IDLE: ;
      S_CHK_CMD, S_WR1, S_WR2, S_QCMD: begin
        next_cyc.we = 1'b1;
        next_cyc.addr = tgt;
        next_cyc.data = (state == S_CHK_CMD) ? fsl_pkg::CMD_READ_STATUS
                      : (state == S_WR1) ? confirm_code(op, cfg)
                      : (state == S_QCMD) ? fsl_pkg::CMD_READ_INFO
                      : first_code(op);
        if (cnt < 16'(STROBE)) begin
          next_cnt = cnt + 16'h0001;
        end else begin
          next_cnt = 16'h0000;
          next_cyc.we = 1'b0;
          case (state)
            S_CHK_CMD: next_state = S_CHK_RD;
            S_QCMD: begin
              next_state = S_QRD;
              // Lock word sits at block base plus 2 words
              next_cyc.addr = tgt + ADDR_W'(fsl_pkg::LOCK_WORD_OFS);
            end
            S_WR2: next_state = (op == fsl_pkg::OP_CLR_STATUS) ? S_DONE : S_WR1;
            default: next_state = S_POLL;
          endcase
        end
        next_rd_en = 1'b0;
      end
      S_CHK_RD, S_POLL, S_QRD: begin
        next_rd_en = 1'b1;
        if (cnt < 16'(STROBE)) begin
          next_cnt = cnt + 16'h0001;
        end else begin
          next_cnt = 16'h0000;
          next_rd_en = 1'b0;
          next_dstat = flash_dq_in[7:0];
          if (state == S_QRD) begin
            next_locked = flash_dq_in[0];
            next_state  = S_DONE;
          end else if (state == S_CHK_RD) begin
            // Device must be ready before a pin-config, lock-set or lock-clear command
            if (!flash_dq_in[fsl_pkg::READY_BIT]) begin
              next_refused = 1'b1;
              next_state   = S_DONE;
            end else if (op == fsl_pkg::OP_PIN_CFG &&
                         (cfg[1:0] & fsl_pkg::PIN_MODE_MASK) ==
                         fsl_pkg::PIN_MODE_UNSUP) begin
              next_refused = 1'b1;
              next_state   = S_DONE;
            end else begin
              next_state = S_WR2;
            end
          end else if (op == fsl_pkg::OP_PIN_CFG ||
                       flash_dq_in[fsl_pkg::READY_BIT]) begin
            // Completion by ready flag, or on the first poll for pin config, error flags kept
            if (op == fsl_pkg::OP_PIN_CFG &&
                !(flash_dq_in[fsl_pkg::LOCK_ERR] &&
                  flash_dq_in[fsl_pkg::ERASE_ERR])) begin
              next_pin_mode = cfg[1:0];
            end
            next_state = S_DONE;
          end else if (polls == 16'(POLL_LIMIT)) begin
            next_timeout = 1'b1;
            next_state   = S_DONE;
          end else begin
            next_polls = polls + 16'h0001;
          end
        end
      end
      S_DONE: begin
        next_busy  = 1'b0;
        next_polls = 16'h0000;
        next_cyc.addr = tgt;
        next_cyc.data = fsl_pkg::CMD_READ_ARRAY;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state    <= S_IDLE;
      tgt      <= '0;
      cfg      <= 8'h00;
      op       <= 3'h0;
      dstat    <= 8'h00;
      busy     <= 1'b0;
      locked   <= 1'b0;
      refused  <= 1'b0;
      timeout  <= 1'b0;
      pin_mode <= 2'h0;
      cnt      <= 16'h0000;
      polls    <= 16'h0000;
      cyc      <= '0;
      rd_en    <= 1'b0;
      sw_rdata <= 32'h0000_0000;
    end else begin
      state    <= next_state;
      tgt      <= next_tgt;
      cfg      <= next_cfg;
      op       <= next_op;
      dstat    <= next_dstat;
      busy     <= next_busy;
      locked   <= next_locked;
      refused  <= next_refused;
      timeout  <= next_timeout;
      pin_mode <= next_pin_mode;
      cnt      <= next_cnt;
      polls    <= next_polls;
      cyc      <= next_cyc;
      rd_en    <= next_rd_en;
      sw_rdata <= next_rdata;
    end
  end

  // Pin registers: all outputs straight from flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flash_addr    <= '0;
      flash_dq_out  <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      reset_pin     <= 1'b0;
    end else begin
      flash_addr    <= next_cyc.addr;
      flash_dq_out  <= next_cyc.data;
      flash_dq_oe_n <= !next_cyc.we;
      flash_ce_n    <= !(next_cyc.we || next_rd_en);
      flash_we_n    <= !next_cyc.we;
      flash_oe_n    <= !next_rd_en;
      reset_pin     <= 1'b1;
    end
  end
endmodule

// *** hw/fsl_pkg.sv ***
// Package with command codes, register offsets and timing for the flash lock host
package fsl_pkg;

  localparam logic [15:0] CMD_PIN_CFG_SETUP = 16'h00B8;
  localparam logic [15:0] CMD_LOCK_SETUP    = 16'h0060;
  localparam logic [15:0] CMD_LOCK_SET      = 16'h0001;
  localparam logic [15:0] CMD_LOCK_CLEAR    = 16'h00D0;
  localparam logic [15:0] CMD_READ_STATUS   = 16'h0070;
  localparam logic [15:0] CMD_CLEAR_STATUS  = 16'h0050;
  localparam logic [15:0] CMD_READ_INFO     = 16'h0090;
  localparam logic [15:0] CMD_READ_ARRAY    = 16'h00FF;

  localparam int READY_BIT    = 7;
  localparam int ERASE_ERR    = 5;
  localparam int LOCK_ERR     = 4;
  localparam int LOCK_WORD_OFS = 2;
  localparam logic [1:0] PIN_MODE_MASK = 2'h3;
  localparam logic [1:0] PIN_MODE_UNSUP = 2'h2;

  // Host registers, word indexes on the software port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_CFG    = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RESULT = 4'h4;

  localparam logic [2:0] OP_PIN_CFG    = 3'h1;
  localparam logic [2:0] OP_LOCK_SET   = 3'h2;
  localparam logic [2:0] OP_LOCK_CLEAR = 3'h3;
  localparam logic [2:0] OP_LOCK_QUERY = 3'h4;
  localparam logic [2:0] OP_CLR_STATUS = 3'h5;

  // Bus cycle timing: strobe width and minimum status pulse width
  localparam int CLK_MHZ     = 40;
  localparam int STROBE_NS   = 75;
  localparam int STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_NS    = 500;
  localparam int PULSE_MIN_CYC = (PULSE_NS * CLK_MHZ) / 1000 / 2;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic        we;
  } fsl_cycle_t;

endpackage

// *** hw/fsl_pulse_catch.sv ***
// Counter that catches completion pulses on the status output pin
`timescale 1ns/10ps
module fsl_pulse_catch #(
  parameter int MIN_LOW = 10
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       pin_low,
  output logic [7:0]      pulse_count
);
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  logic [7:0] next_pulse_count;

  always_comb begin
    next_low_cnt = pin_low ? ((low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01)
                           : 8'h00;
    next_pulse_count = pulse_count;
    if (!pin_low && low_cnt >= 8'(MIN_LOW)) begin
      next_pulse_count = pulse_count + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      low_cnt     <= 8'h00;
      pulse_count <= 8'h00;
    end else begin
      low_cnt     <= next_low_cnt;
      pulse_count <= next_pulse_count;
    end
  end
endmodule

// *** bench/fsl_host_properties.sv ***
// Checker for the host's flash bus cycles and register port
`timescale 1ns/10ps
module fsl_host_properties #(
  parameter int ADDR_W = 24
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              sw_rd,
  input  wire logic [31:0]       sw_rdata,
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic [15:0]       flash_dq_out,
  input  wire logic              flash_dq_oe_n,
  input  wire logic              flash_ce_n,
  input  wire logic              flash_we_n,
  input  wire logic              flash_oe_n,
  input  wire logic              reset_pin
);
  logic              we_q;
  logic [15:0]       last_d;
  logic [ADDR_W-1:0] last_a;
  wire               wstart = we_q && !flash_we_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Previous write, so a confirm cycle can be judged against its setup
  always_ff @(posedge ref_clk) begin
    we_q <= flash_we_n;
    if (reset) begin
      last_d <= 16'h0000;
    end else if (wstart) begin
      last_d <= flash_dq_out;
      last_a <= flash_addr;
    end
  end
  a_reset_pin_low: assert property (disable iff (1'b0)
    reset |=> !reset_pin) else $error("reset pin high in reset");
  a_read_idle_zero: assert property (!sw_rd |=> sw_rdata == 32'h0)
    else $error("read data without read");
  a_strobes_apart: assert property (flash_we_n || flash_oe_n)
    else $error("write and read strobes overlap");
  a_write_drives: assert property (!flash_we_n |-> !flash_dq_oe_n
    && !flash_ce_n) else $error("write without drive or select");
  a_read_floats: assert property (!flash_oe_n |-> flash_dq_oe_n
    && !flash_ce_n) else $error("read with bus driven");
  a_write_width: assert property ($fell(flash_we_n) |->
    !flash_we_n [*3] ##1 flash_we_n) else $error("write strobe width");
  a_read_width: assert property ($fell(flash_oe_n) |->
    !flash_oe_n [*3] ##1 flash_oe_n) else $error("read strobe width");
  a_cfg_confirm: assert property (
    wstart && last_d == fsl_pkg::CMD_PIN_CFG_SETUP |->
    flash_addr == last_a && flash_dq_out[1:0] != fsl_pkg::PIN_MODE_UNSUP)
    else $error("bad pin config confirm");
  a_lock_confirm: assert property (
    wstart && last_d == fsl_pkg::CMD_LOCK_SETUP |-> flash_addr == last_a
    && (flash_dq_out == fsl_pkg::CMD_LOCK_SET
    || flash_dq_out == fsl_pkg::CMD_LOCK_CLEAR))
    else $error("bad lock confirm");
endmodule

// *** bench/fsl_flash_model.sv ***
// Behavioural flash device answering pin-mode and lock commands
`timescale 1ns/10ps
module fsl_flash_model #(
  parameter int BUSY = 40
) (
  input  wire logic        ref_clk,
  input  wire logic [23:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  output logic      [15:0] flash_dq_in,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        reset_pin,
  output logic             status_output_pin
);
  // Locked blocks would refuse erase and program, neither is modelled
  logic        lock [256] = '{default: 1'b0};
  logic        program_enable_supply = 1'b1; // Above enable_lockout_level
  logic [15:0] pend = 16'h0;
  logic [15:0] wd = 16'h0;
  logic [15:0] junk = 16'h5A5A;
  logic [15:0] rv;
  logic [23:0] wa = 24'h0;
  logic [1:0]  rmode = 2'h0;
  logic [1:0]  pin_mode = 2'h0;
  logic        wl = 1'b0;
  logic        err4 = 1'b0;
  logic        err5 = 1'b0;
  int          cnt = 0;
  always @(posedge ref_clk) begin
    junk <= ~junk;
    if (cnt > 0) cnt <= cnt - 1;
    if (!reset_pin) begin
      pin_mode <= 2'h0;
      pend <= 16'h0;
      rmode <= 2'h0;
      wl <= 1'b0;
    end else if (!flash_we_n && !flash_ce_n) begin
      wa <= flash_addr;
      wd <= flash_dq_out;
      wl <= 1'b1;
    end else if (wl) begin
      wl <= 1'b0;
      pend <= 16'h0;
      if (pend == fsl_pkg::CMD_PIN_CFG_SETUP) begin
        if (wd[1:0] == fsl_pkg::PIN_MODE_UNSUP) begin
          err4 <= 1'b1;
          err5 <= 1'b1;
        end else pin_mode <= wd[1:0];
      end else if (pend == fsl_pkg::CMD_LOCK_SETUP) begin
        cnt <= BUSY;
        if (cnt != 0 || !program_enable_supply) begin
          if (wd == fsl_pkg::CMD_LOCK_SET) err4 <= 1'b1;
          else err5 <= 1'b1;
        end else if (wd == fsl_pkg::CMD_LOCK_SET) begin
          lock[wa[23:16]] <= 1'b1;
        end else if (wd == fsl_pkg::CMD_LOCK_CLEAR) begin
          lock <= '{default: 1'b0};
        end
      end else begin
        case (wd)
          fsl_pkg::CMD_PIN_CFG_SETUP: pend <= wd;
          fsl_pkg::CMD_LOCK_SETUP: begin
            pend <= wd;
            rmode <= 2'h1;
          end
          fsl_pkg::CMD_READ_STATUS: rmode <= 2'h1;
          fsl_pkg::CMD_CLEAR_STATUS: begin
            err4 <= 1'b0;
            err5 <= 1'b0;
          end
          fsl_pkg::CMD_READ_INFO: rmode <= 2'h2;
          fsl_pkg::CMD_READ_ARRAY: rmode <= 2'h0;
          default: ;
        endcase
      end
    end
  end
  always_comb begin
    case (rmode)
      2'h1: rv = {8'h00, cnt == 0, 1'b0, err5, err4, 4'h0};
      2'h2: rv = {15'h0, lock[flash_addr[23:16]] &&
                         flash_addr[15:0] == 16'h0002};
      default: rv = 16'hFFFF;
    endcase
  end
  // No erase or program here, so pulse modes never pull the pin low
  assign status_output_pin = pin_mode != 2'h0 || cnt == 0;
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rv : junk;
endmodule

// *** bench/test_flash_status_pin_and_block_lock.sv ***
// Self-checking bench for the flash pin-mode and block-lock host
`timescale 1ns/10ps
module test_flash_status_pin_and_block_lock;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [31:0] sw_rdata, st, c0;
  logic [23:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic        flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
  logic        reset_pin, status_output_pin;
  int          err_count = 0;
  int          num_checks = 0;
  logic [7:0]  codes [4] = '{8'h01, 8'hFD, 8'h03, 8'h00};
  logic [1:0]  modes [4] = '{2'h1, 2'h1, 2'h3, 2'h0};
  initial forever #12.5 ref_clk = ~ref_clk;
  fsl_host uut (.*);
  fsl_flash_model dev (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic op(input logic [2:0] code, input logic [23:0] a);
    wr(fsl_pkg::REG_ADDR, {8'h0, a});
    wr(fsl_pkg::REG_CTRL, {29'h0, code});
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 500; i++) begin
      rd(fsl_pkg::REG_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    chk({30'h0, st[3], st[0]}, 32'h0);
  endtask
  task automatic query(input logic [23:0] a, input logic exp);
    op(fsl_pkg::OP_LOCK_QUERY, a);
    chk({31'h0, st[1]}, {31'h0, exp});
  endtask
  task automatic do_reset;
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    do_reset;
    foreach (codes[i]) begin
      wr(fsl_pkg::REG_CFG, {24'h0, codes[i]});
      op(fsl_pkg::OP_PIN_CFG, 24'h0);
      chk({30'h0, st[5:4]}, {30'h0, modes[i]});
    end
    $display("test pin modes done");
    wr(fsl_pkg::REG_CFG, 32'h2);
    op(fsl_pkg::OP_PIN_CFG, 24'h0);
    chk({26'h0, st[5:4], 4'h0} | {29'h0, st[2], 2'h0}, 32'h4);
    $display("test unsupported code done");
    op(fsl_pkg::OP_LOCK_SET, 24'h050123);
    rd(fsl_pkg::REG_RESULT, st);
    chk(st & 32'hB0, 32'h80);
    query(24'h050000, 1'b1);
    query(24'h060000, 1'b0);
    $display("test lock set done");
    wr(fsl_pkg::REG_CFG, 32'h3);
    op(fsl_pkg::OP_PIN_CFG, 24'h0);
    chk({30'h0, st[5:4]}, 32'h3);
    op(fsl_pkg::OP_LOCK_SET, 24'h060000);
    chk({24'h0, st[31:24]}, 32'h1);
    do_reset;
    rd(fsl_pkg::REG_STATUS, c0);
    chk({c0[31:24], 22'h0, c0[5:4]}, 32'h0);
    op(fsl_pkg::OP_LOCK_SET, 24'h070000);
    chk({24'h0, st[31:24]}, 32'h1);
    query(24'h050000, 1'b1);
    $display("test reset and pin level done");
    op(fsl_pkg::OP_LOCK_CLEAR, 24'h000000);
    query(24'h050000, 1'b0);
    query(24'h070000, 1'b0);
    op(fsl_pkg::OP_CLR_STATUS, 24'h0);
    $display("test clear all done");
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    print_verdict;
  end
endmodule
bind fsl_host fsl_host_properties #(.ADDR_W(ADDR_W)) chk (
  .ref_clk(ref_clk), .reset(reset), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .reset_pin(reset_pin));
